// [eeec_pkg.sv]
// Constants, register map and helpers for the external edge event controller
`default_nettype none

package eeec_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NLINE    = 25;
  localparam int NSEL     = 16;
  localparam int NDIRECT  = NLINE - NSEL;
  localparam int NPIN     = 168;
  localparam int SEL_W    = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = DATA_W / 8;
  localparam int BYTE_W   = 8;
  localparam int NSEL_REG = NSEL / STRB_W;
  localparam int ISR_W    = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_IMR   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EMR   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RISE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FALL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PEND  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SEL0  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STEP  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ISR   = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IMSK  = 8'h28;

  // Block status bits
  localparam int ISR_PEND_BIT   = 0;
  localparam int ISR_SELERR_BIT = 1;

  // Reset values
  localparam logic [NLINE-1:0] RST_LINES = 25'h0000000;
  localparam logic [SEL_W-1:0] RST_SEL   = 8'h00;
  localparam logic [ISR_W-1:0] RST_ISR   = 2'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;

  // Byte-lane merge of a write into an old register value
  function automatic logic [DATA_W-1:0] eeec_merge
    (input logic [DATA_W-1:0] old_v,
     input logic [DATA_W-1:0] new_v,
     input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int k = 0; k < STRB_W; k++)
    begin
      if (strb[k])
        r[BYTE_W*k +: BYTE_W] = new_v[BYTE_W*k +: BYTE_W];
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// [eeec_line_if.sv]
// One detection line: its source level and the edge pulses it produced
`timescale 1ns/1ps
`default_nettype none

interface eeec_line_if;
  logic src;
  logic rise;
  logic fall;

  modport feed    (output src);
  modport catcher (input src, output rise, output fall);
  modport ctrl    (input rise, input fall);
endinterface

`default_nettype wire

// [eeec_pin_sel.sv]
// Routes one chosen pin onto a selectable detection line
`timescale 1ns/1ps
`default_nettype none

module eeec_pin_sel #(
  parameter int NPIN = eeec_pkg::NPIN
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [NPIN-1:0]             pins,
  input  wire logic [eeec_pkg::SEL_W-1:0]  sel,
  eeec_line_if.feed                        lf
);

  // Out-of-range index reads low so no phantom edges appear
  assign lf.src = (int'(sel) < NPIN) ? pins[sel] : 1'b0;

  property p_pin_route;
    @(posedge pclk) disable iff (!presetn)
    (int'(sel) < NPIN) |-> (lf.src == pins[sel]);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("selected pin not routed to line");

endmodule

`default_nettype wire

// [eeec_edge_catch.sv]
// Catches edges of one line, also pulses narrower than a clock period
`timescale 1ns/1ps
`default_nettype none

module eeec_edge_catch (
  input  wire logic  pclk,
  input  wire logic  presetn,
  eeec_line_if.catcher lf
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic       rise;
    logic       fall;
  } eeec_catch_s;

  eeec_catch_s s_r;
  eeec_catch_s s_nxt;
  logic        rise_tgl_r;
  logic        fall_tgl_r;

  // ****************************************************************
  // Line-clocked toggles
  // ****************************************************************
  // The line itself clocks these, so a glitch too short for pclk
  // still flips a toggle and cannot slip between samples
  always_ff @(posedge lf.src or negedge presetn)
  begin
    if (!presetn)
      rise_tgl_r <= 1'b0;
    else
      rise_tgl_r <= ~rise_tgl_r;
  end

  always_ff @(negedge lf.src or negedge presetn)
  begin
    if (!presetn)
      fall_tgl_r <= 1'b0;
    else
      fall_tgl_r <= ~fall_tgl_r;
  end

  // ****************************************************************
  // Crossing into pclk
  // ****************************************************************
  // First stage feeds only the second; pulse from toggle change
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.s1   = {fall_tgl_r, rise_tgl_r};
    s_nxt.s2   = s_r.s1;
    s_nxt.s3   = s_r.s2;
    s_nxt.rise = s_r.s2[0] ^ s_r.s3[0];
    s_nxt.fall = s_r.s2[1] ^ s_r.s3[1];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign lf.rise = s_r.rise;
  assign lf.fall = s_r.fall;

  property p_short_edge;
    @(posedge pclk) disable iff (!presetn)
    ($changed(rise_tgl_r) || $changed(fall_tgl_r))
      |-> ##[1:4] (s_r.rise || s_r.fall);
  endproperty
  a_short_edge: assert property (p_short_edge)
    else $error("captured edge never reached pclk side");

endmodule

`default_nettype wire

// [eeec_ctrl.sv]
// Top of the external edge event controller with its APB register file
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module eeec_ctrl #(
  parameter int NPIN = eeec_pkg::NPIN
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [eeec_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [eeec_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [eeec_pkg::STRB_W-1:0]   pstrb,
  output logic      [eeec_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NPIN-1:0]               gpio_in,
  input  wire logic [eeec_pkg::NDIRECT-1:0]  direct_in,
  output logic      [eeec_pkg::NLINE-1:0]    irq_req,
  output logic      [eeec_pkg::NLINE-1:0]    evt_req,
  output logic                               irq
);

  localparam int NL = eeec_pkg::NLINE;
  localparam int NS = eeec_pkg::NSEL;
  localparam int DW = eeec_pkg::DATA_W;

  typedef struct packed {
    logic [NL-1:0]                           imr;
    logic [NL-1:0]                           emr;
    logic [NL-1:0]                           rts;
    logic [NL-1:0]                           fts;
    logic [NL-1:0]                           pend;
    logic [NL-1:0]                           evt;
    logic [NS-1:0][eeec_pkg::SEL_W-1:0]      sel;
    logic [eeec_pkg::ISR_W-1:0]              isr;
    logic [eeec_pkg::ISR_W-1:0]              imsk;
    logic [DW-1:0]                           rdata;
    logic                                    slverr;
  } eeec_state_s;

  eeec_state_s   s_r;
  eeec_state_s   s_nxt;
  logic [NL-1:0] rise_v;
  logic [NL-1:0] fall_v;
  logic [NL-1:0] trig;
  logic [NL-1:0] pend_set;
  logic [NL-1:0] clr_mask;
  logic          wr_acc;
  logic          rd_acc;
  logic          setup;

  // Known register offsets; anything else answers with an error
  function automatic logic eeec_is_mapped
    (input logic [eeec_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = (a == eeec_pkg::OFF_IMR)  || (a == eeec_pkg::OFF_EMR)  ||
          (a == eeec_pkg::OFF_RISE) || (a == eeec_pkg::OFF_FALL) ||
          (a == eeec_pkg::OFF_PEND) || (a == eeec_pkg::OFF_ISR)  ||
          (a == eeec_pkg::OFF_IMSK);
    for (int k = 0; k < eeec_pkg::NSEL_REG; k++)
    begin
      if (a == eeec_pkg::OFF_SEL0 +
               eeec_pkg::ADDR_W'(k) * eeec_pkg::OFF_STEP)
        hit = 1'b1;
    end
    return hit;
  endfunction

  // ****************************************************************
  // Line sources and edge capture
  // ****************************************************************
  eeec_line_if lif [NL] ();

  // Pin-fed lines first, then the directly wired ones
  generate
    for (genvar i = 0; i < NL; i++)
    begin : g_line
      if (i < NS)
      begin : g_pin
        eeec_pin_sel #(.NPIN(NPIN)) u_sel (
          .pclk    (pclk),
          .presetn (presetn),
          .pins    (gpio_in),
          .sel     (s_r.sel[i]),
          .lf      (lif[i])
        );
      end
      else
      begin : g_dir
        assign lif[i].src = direct_in[i-NS];
      end
      eeec_edge_catch u_catch (
        .pclk    (pclk),
        .presetn (presetn),
        .lf      (lif[i])
      );
      assign rise_v[i] = lif[i].rise;
      assign fall_v[i] = lif[i].fall;
    end
  endgenerate

  // ****************************************************************
  // Trigger selection and bus strobes
  // ****************************************************************
  // Both edges enabled on a line gives a trigger on either
  assign trig     = (rise_v & s_r.rts) | (fall_v & s_r.fts);
  assign pend_set = trig & s_r.imr;
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  // Only bytes enabled by pstrb carry clear requests
  assign clr_mask = (wr_acc && paddr == eeec_pkg::OFF_PEND) ?
                    NL'(eeec_pkg::eeec_merge('0, pwdata, pstrb)) : '0;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [DW-1:0] rd;
    logic [DW-1:0] m;
    rd = eeec_pkg::RST_DATA;
    m  = eeec_pkg::RST_DATA;
    s_nxt = s_r;
    s_nxt.evt = trig & s_r.emr;
    // Register writes at the access edge
    if (wr_acc)
    begin
      case (paddr)
        eeec_pkg::OFF_IMR:
          s_nxt.imr = NL'(eeec_pkg::eeec_merge(DW'(s_r.imr), pwdata, pstrb));
        eeec_pkg::OFF_EMR:
          s_nxt.emr = NL'(eeec_pkg::eeec_merge(DW'(s_r.emr), pwdata, pstrb));
        eeec_pkg::OFF_RISE:
          s_nxt.rts = NL'(eeec_pkg::eeec_merge(DW'(s_r.rts), pwdata, pstrb));
        eeec_pkg::OFF_FALL:
          s_nxt.fts = NL'(eeec_pkg::eeec_merge(DW'(s_r.fts), pwdata, pstrb));
        eeec_pkg::OFF_IMSK:
          s_nxt.imsk = eeec_pkg::ISR_W'(pwdata);
        default:
          s_nxt.imsk = s_r.imsk;
      endcase
      // Selector bytes; an index past the last pin is flagged
      for (int k = 0; k < eeec_pkg::NSEL_REG; k++)
      begin
        if (paddr == eeec_pkg::OFF_SEL0 +
                     eeec_pkg::ADDR_W'(k) * eeec_pkg::OFF_STEP)
        begin
          for (int b = 0; b < eeec_pkg::STRB_W; b++)
          begin
            if (pstrb[b])
            begin
              s_nxt.sel[k*eeec_pkg::STRB_W+b] =
                pwdata[eeec_pkg::BYTE_W*b +: eeec_pkg::BYTE_W];
              if (int'(pwdata[eeec_pkg::BYTE_W*b +: eeec_pkg::BYTE_W])
                  >= NPIN)
                s_nxt.isr[eeec_pkg::ISR_SELERR_BIT] = 1'b1;
            end
          end
        end
      end
    end
    // Pending: clear by writing one, a new set wins the same cycle
    s_nxt.pend = (s_r.pend & ~clr_mask) | pend_set;
    // Status read clears; events of that same cycle survive
    if (rd_acc && paddr == eeec_pkg::OFF_ISR)
      s_nxt.isr = eeec_pkg::RST_ISR;
    if (|pend_set)
      s_nxt.isr[eeec_pkg::ISR_PEND_BIT] = 1'b1;
    if (wr_acc && s_nxt.isr[eeec_pkg::ISR_SELERR_BIT])
      s_nxt.isr[eeec_pkg::ISR_SELERR_BIT] = 1'b1;
    // Read data is fetched in setup so it comes from a flop
    case (paddr)
      eeec_pkg::OFF_IMR:  rd = DW'(s_r.imr);
      eeec_pkg::OFF_EMR:  rd = DW'(s_r.emr);
      eeec_pkg::OFF_RISE: rd = DW'(s_r.rts);
      eeec_pkg::OFF_FALL: rd = DW'(s_r.fts);
      eeec_pkg::OFF_PEND: rd = DW'(s_r.pend);
      eeec_pkg::OFF_ISR:  rd = DW'(s_r.isr);
      eeec_pkg::OFF_IMSK: rd = DW'(s_r.imsk);
      default:            rd = eeec_pkg::RST_DATA;
    endcase
    for (int k = 0; k < eeec_pkg::NSEL_REG; k++)
    begin
      if (paddr == eeec_pkg::OFF_SEL0 +
                   eeec_pkg::ADDR_W'(k) * eeec_pkg::OFF_STEP)
      begin
        for (int b = 0; b < eeec_pkg::STRB_W; b++)
          m[eeec_pkg::BYTE_W*b +: eeec_pkg::BYTE_W] =
            s_r.sel[k*eeec_pkg::STRB_W+b];
        rd = m;
      end
    end
    if (setup)
    begin
      s_nxt.rdata  = pwrite ? eeec_pkg::RST_DATA : rd;
      s_nxt.slverr = ~eeec_is_mapped(paddr);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r        <= '0;
      s_r.imr    <= eeec_pkg::RST_LINES;
      s_r.isr    <= eeec_pkg::RST_ISR;
      s_r.rdata  <= eeec_pkg::RST_DATA;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // No wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = s_r.rdata;
  assign pslverr = s_r.slverr;
  assign irq_req = s_r.pend & s_r.imr;
  assign evt_req = s_r.evt;
  assign irq     = |(s_r.isr & s_r.imsk);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_pend_set;
    @(posedge pclk) disable iff (!presetn)
    (|pend_set) |=> ((s_r.pend & $past(pend_set)) == $past(pend_set));
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("unmasked trigger did not set pending");

  property p_mask_block;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((s_r.pend & ~$past(s_r.pend) & ~$past(s_r.imr)) == '0);
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("masked line became pending");

  property p_edge_sel;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((s_r.pend & ~$past(s_r.pend) & ~$past(trig)) == '0);
  endproperty
  a_edge_sel: assert property (p_edge_sel)
    else $error("pending set without a selected edge");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    (|clr_mask) |=>
      ((s_r.pend & $past(clr_mask) & ~$past(pend_set)) == '0);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear pending");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (($past(s_r.pend) & ~s_r.pend & ~$past(clr_mask)) == '0);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pending bit lost without a clear");

  property p_req_out;
    @(posedge pclk) disable iff (!presetn)
    (|pend_set) |=> ##[0:1] ((irq_req & $past(pend_set)) != '0);
  endproperty
  a_req_out: assert property (p_req_out)
    else $error("pending line gave no request");

  // A selector byte must land in the line it addresses
  property p_sel_store;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == eeec_pkg::OFF_SEL0 && pstrb[0]) |=>
      (s_r.sel[0] == $past(pwdata[eeec_pkg::SEL_W-1:0]));
  endproperty
  a_sel_store: assert property (p_sel_store)
    else $error("selector byte not stored");

  // A bad index must be reported, as the line then goes silent
  property p_sel_err;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == eeec_pkg::OFF_SEL0 && pstrb[0] &&
     int'(pwdata[eeec_pkg::SEL_W-1:0]) >= NPIN)
      |=> s_r.isr[eeec_pkg::ISR_SELERR_BIT];
  endproperty
  a_sel_err: assert property (p_sel_err)
    else $error("bad selector index not flagged");

  // Stale status after a read would hold the interrupt up
  property p_isr_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == eeec_pkg::OFF_ISR && !(|pend_set)) |=>
      (s_r.isr == eeec_pkg::RST_ISR);
  endproperty
  a_isr_clear: assert property (p_isr_clear)
    else $error("status read did not clear block status");

endmodule

`default_nettype wire

// [eeec_dummy_note_none.sv]
// Intentionally empty marker of no further logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [eeec_pin_drv.sv]
// Model of the pins and direct sources that feed the edge lines
`timescale 1ns/1ps
`default_nettype none

module eeec_pin_drv #(
  parameter int NPIN = eeec_pkg::NPIN
) (
  output var logic [NPIN-1:0]              gpio_in,
  output var logic [eeec_pkg::NDIRECT-1:0] direct_in
);
  // ****************************************************************
  // Source levels
  // ****************************************************************
  // Idle low, as an input with a pull-down would sit
  initial
  begin
    gpio_in   = '0;
    direct_in = '0;
  end

  // High pulse on a set of pins, placed away from any clock edge
  task automatic pulse(input logic [NPIN-1:0] m, input int w);
    #13;
    gpio_in = m;
    #(w);
    gpio_in = '0;
  endtask

  // Direct sources change just after a clock edge
  task automatic set_dir(input logic [eeec_pkg::NDIRECT-1:0] v);
    direct_in <= v;
  endtask
endmodule

`default_nettype wire

// [test_external_edge_event_controller.sv]
// Self-checking testbench of the external edge event controller
`timescale 1ns/1ps
`default_nettype none

module test_external_edge_event_controller;
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [eeec_pkg::ADDR_W-1:0]   paddr;
  logic [eeec_pkg::DATA_W-1:0]   pwdata;
  logic [eeec_pkg::DATA_W-1:0]   prdata;
  logic [eeec_pkg::STRB_W-1:0]   pstrb;
  logic                          pready;
  logic                          pslverr;
  logic                          irq;
  logic [eeec_pkg::NPIN-1:0]     gpio_in;
  logic [eeec_pkg::NPIN-1:0]     pm;
  logic [eeec_pkg::NDIRECT-1:0]  direct_in;
  logic [eeec_pkg::NLINE-1:0]    irq_req;
  logic [eeec_pkg::NLINE-1:0]    evt_req;
  logic [31:0]                   rd;
  logic                          er;
  int                            n_fail;
  int                            compares;
  int                            cyc;
  int                            seed;
  int                            evt_n;
  int                            base;
  int                            k;
  int                            l;

  eeec_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .direct_in(direct_in), .irq_req(irq_req),
    .evt_req(evt_req), .irq(irq));

  eeec_pin_drv drv_u (.gpio_in(gpio_in), .direct_in(direct_in));

  // ****************************************************************
  // Clock, timeout and event counting
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // A hung handshake would otherwise stall the run forever
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (evt_req[0] === 1'b1)
      evt_n = evt_n + 1;
    if (cyc == 5000)
    begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ****************************************************************
  // Tasks and expectation helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    compares = compares + 1;
    if (s !== e)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; idle cycle first so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, 4'hF);
    chk("prdata", e, rd);
  endtask

  // Settling time for an edge to reach the pending store
  task automatic wt();
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic [31:0] bit_at(input int n, input logic on);
    return on ? (32'h00000001 << n) : 32'h00000000;
  endfunction

  // Selector word k when lines 0..15 take pins base upwards
  function automatic logic [31:0] selw(input int b, input int n);
    logic [31:0] r;
    for (int j = 0; j < 4; j++)
      r[8*j +: 8] = 8'(b + 4*n + j);
    return r;
  endfunction

  task automatic end_sim();
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 32'h92b8f410;
    {n_fail, compares, cyc, evt_n} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h28; a += 4)
      rc(8'(a), 32'h00000000);
    apb(1'b0, 8'h2C, 32'h00000000, 4'hF);
    chk("pslverr", 32'h1, {31'h0, er});
    base = {$random(seed)} % 152;
    for (int n = 0; n < 4; n++)
      wr(8'(8'h14 + 4*n), selw(base, n));
    wr(8'h00, 32'h01FFFFFF);
    wr(8'h08, 32'h01FFFFFF);
    wr(8'h04, 32'h00000001);
    wr(8'h28, 32'h00000001);
    drv_u.set_dir(9'h1FF);
    pm = '0;
    for (int n = 0; n < 16; n++)
      pm[base + n] = 1'b1;
    drv_u.pulse(pm, 30);
    wt();
    rc(8'h10, 32'h01FFFFFF);
    chk("irq_req", 32'h01FFFFFF, {7'h00, irq_req});
    chk("irq", 32'h1, {31'h0, irq});
    chk("evt_n", 32'h1, evt_n);
    rc(8'h24, 32'h00000001);
    rc(8'h24, 32'h00000000);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h10, 32'h00000000);
    rc(8'h10, 32'h01FFFFFF);
    wr(8'h10, 32'h0000FFFF);
    rc(8'h10, 32'h01FF0000);
    wr(8'h10, 32'h01FFFFFF);
    rc(8'h10, 32'h00000000);
    drv_u.set_dir(9'h000);
    wt();
    wr(8'h10, 32'h01FFFFFF);
    k = {$random(seed)} % 9;
    l = 16 + k;
    for (int m = 1; m < 4; m++)
    begin
      wr(8'h08, bit_at(l, m[0]));
      wr(8'h0C, bit_at(l, m[1]));
      drv_u.set_dir(9'h001 << k);
      wt();
      rc(8'h10, bit_at(l, m[0]));
      wr(8'h10, 32'h01FFFFFF);
      drv_u.set_dir(9'h000);
      wt();
      rc(8'h10, bit_at(l, m[1]));
      wr(8'h10, 32'h01FFFFFF);
    end
    wr(8'h08, 32'h01FFFFFF);
    wr(8'h00, 32'h01FFFFFE);
    pm = '0;
    pm[base] = 1'b1;
    pm[base + 1] = 1'b1;
    pm[base + 16] = 1'b1;
    drv_u.pulse(pm, 20);
    wt();
    rc(8'h10, 32'h00000002);
    chk("irq_req", 32'h2, {7'h00, irq_req});
    chk("evt_n", 32'h2, evt_n);
    rc(8'h24, 32'h00000001);
    apb(1'b1, 8'h14, 32'h000000FF, 4'h1);
    rc(8'h14, {selw(base, 0) & 32'hFFFFFF00} | 32'hFF);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h28, 32'h00000003);
    // Let the access edge settle before looking at the level
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rc(8'h24, 32'h00000002);
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    end_sim();
  end
endmodule

`default_nettype wire
